// >>> tlpic_pkg.sv
// Purpose: Shared constants and types for the two-level interrupt controller
// Assumes: 8-bit register port, 21-bit program counter
// Notes:   Offsets index the plain register port
package tlpic_pkg;

    localparam int VEC_W = 21;
    localparam int DAT_W = 8;
    localparam int ADR_W = 4;

    localparam logic [VEC_W-1:0] HI_VEC_ADDR = 21'h000008;
    localparam logic [VEC_W-1:0] LO_VEC_ADDR = 21'h000018;

    localparam logic [ADR_W-1:0] OFF_IRQ_CTRL  = 4'h0;
    localparam logic [ADR_W-1:0] OFF_RST_CTRL  = 4'h1;
    localparam logic [ADR_W-1:0] OFF_PFLAG2    = 4'h2;
    localparam logic [ADR_W-1:0] OFF_PEN2      = 4'h3;
    localparam logic [ADR_W-1:0] OFF_PPRIO2    = 4'h4;
    localparam logic [ADR_W-1:0] OFF_EXT_CFG   = 4'h5;
    localparam logic [ADR_W-1:0] OFF_SVC_STAT  = 4'h6;

    // irq_control_reg fields
    localparam int B_GIE_HI  = 7;
    localparam int B_GIE_LO  = 6;
    localparam int B_EXT_EN  = 4;
    localparam int B_EXT_FLG = 1;
    // reset_control_reg field
    localparam int B_PRIO_EN = 7;
    // peripheral_flag_two fields
    localparam int B_OSC_FAIL = 7;
    localparam int B_NV_DONE  = 4;
    localparam int B_LOW_SUP  = 2;
    localparam int B_CCP2     = 0;
    // ext config and status fields
    localparam int B_EXT_PRIO = 2;
    localparam int B_ST_HI    = 7;
    localparam int B_ST_LO    = 6;

    localparam logic [DAT_W-1:0] PFLAG2_IMPL = 8'h95;
    localparam logic [DAT_W-1:0] PFLAG2_RST  = 8'h00;
    localparam logic [DAT_W-1:0] PEN2_RST    = 8'h00;
    localparam logic [DAT_W-1:0] PPRIO2_RST  = 8'h95;
    localparam logic             EXT_PRIO_RST = 1'b1;

    localparam logic [1:0] CCP_CAPTURE = 2'h0;
    localparam logic [1:0] CCP_COMPARE = 2'h1;
    localparam logic [1:0] CCP_PWM     = 2'h2;

    typedef enum logic [1:0] {
        SVC_NONE,
        SVC_LO,
        SVC_HI,
        SVC_HI_OVER_LO
    } tlpic_svc_t;

    typedef struct packed {
        logic             valid;
        logic             push_ret;
        logic             high;
        logic [VEC_W-1:0] addr;
    } tlpic_vec_t;

    typedef struct packed {
        logic osc_fail;
        logic nv_write_done;
        logic low_supply;
        logic ccp_event;
    } tlpic_evt_t;

endpackage : tlpic_pkg

// >>> tlpic_flag_bank.sv
// Purpose: Sticky interrupt flags, hardware set and software written
// Assumes: Unimplemented bits are masked by IMPL
// Notes:   A set in the same cycle as a software clear is kept
module tlpic_flag_bank
    import tlpic_pkg::*;
#(
    parameter int           W    = 8,
    parameter logic [W-1:0] IMPL = '1,
    parameter logic [W-1:0] RST  = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic [W-1:0] set_evt,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] flags_r
);

    logic [W-1:0] flags_nxt;

    always_comb begin
        flags_nxt = wr_en ? wr_data : flags_r;
        flags_nxt = (flags_nxt | set_evt) & IMPL;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flags_r <= RST & IMPL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    AST_FLAG_SET_WINS: assert property (@(posedge clk_sys) disable iff (srst)
        |(set_evt & IMPL) |=> |(flags_r & $past(set_evt & IMPL)))
        else $error("Flag set lost");

endmodule // tlpic_flag_bank

// >>> tlpic_ctrl.sv
// Purpose: Two-level priority interrupt controller with compatibility mode
// Assumes: Core pulses instr_done at least every second cycle
// Operation
// - High priority vectors to 000008h, low priority to 000018h.
// - High priority request preempts a running low priority routine.
// - Each source has flag, enable and a priority bit.
// - Priority operation active only while priority_feature_enable is set.
// - With priority on, control bit 7 enables high priority sources.
// - With priority on, control bit 6 enables low priority sources.
// - Flag, enable and matching global enable set give immediate vectoring.
// - Priority feature off by default; priority bits then ignored.
// - Compatibility: bit 6 gates peripherals, bit 7 gates everything.
// - Compatibility mode always uses vector 000008h.
// - Taking an interrupt clears the global enable of that level.
// - No low priority service while high priority is in service.
// - Vectoring pushes return address and loads the vector address.
// - Return from interrupt sets the enable cleared on entry.
// - Flags set by events regardless of any enable.
// - External pin interrupt latency three to four cycles.
// - Flag two bit 7 sets on oscillator failure, sticky.
// - Flag two bit 4 sets on nonvolatile write completion, sticky.
// - Flag two bit 2 sets on low supply detection, sticky.
// - Flag two bit 0 sets on capture or compare; unused in PWM.
// - Flag two bits 6, 5, 3 and 1 read as zero.
module tlpic_ctrl
    import tlpic_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [ADR_W-1:0] reg_addr,
    input  wire logic [DAT_W-1:0] reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [DAT_W-1:0] reg_rdata_r,
    input  wire tlpic_evt_t       periph_evt,
    input  wire logic [1:0]       ccp_mode,
    input  wire logic             ext_pin,
    input  wire logic             instr_done,
    input  wire logic             ret_irq,
    output tlpic_vec_t            vec_r,
    output logic                  hi_active_r,
    output logic                  lo_active_r
);

    logic             prio_en_r;
    logic             gie_hi_r;
    logic             gie_lo_r;
    logic             ext_en_r;
    logic             ext_prio_r;
    logic [DAT_W-1:0] pen2_r;
    logic [DAT_W-1:0] pprio2_r;
    logic [DAT_W-1:0] pflag2_r;
    logic [0:0]       ext_flag_r;
    logic             ext_pin_r;
    logic             cand_hi_r;
    logic             cand_lo_r;
    tlpic_svc_t       svc_r;
    tlpic_svc_t       svc_nxt;

    logic             wr_ctrl;
    logic             wr_pflag2;
    logic             wr_ext;
    logic [DAT_W-1:0] pflag_set;
    logic             ccp_hit;
    logic             ext_edge;
    logic             any_hi;
    logic             any_lo;
    logic             any_per;
    logic             cand_hi_nxt;
    logic             cand_lo_nxt;
    logic             take_hi;
    logic             take_lo;
    logic [DAT_W-1:0] rd_mux;

    // Source is live when flag and enable are set and priority matches
    function automatic logic src_live(input logic [DAT_W-1:0] flg,
                                      input logic [DAT_W-1:0] en,
                                      input logic [DAT_W-1:0] pri,
                                      input logic             want_hi);
        logic [DAT_W-1:0] sel;
        sel = want_hi ? pri : ~pri;
        return |(flg & en & sel);
    endfunction

    assign wr_ctrl   = reg_wr && (reg_addr == OFF_IRQ_CTRL);
    assign wr_pflag2 = reg_wr && (reg_addr == OFF_PFLAG2);
    assign wr_ext    = wr_ctrl;

    // PWM mode has no use for the capture/compare flag
    assign ccp_hit  = periph_evt.ccp_event && (ccp_mode != CCP_PWM);
    assign ext_edge = ext_pin && !ext_pin_r;

    always_comb begin
        pflag_set             = '0;
        pflag_set[B_OSC_FAIL] = periph_evt.osc_fail;
        pflag_set[B_NV_DONE]  = periph_evt.nv_write_done;
        pflag_set[B_LOW_SUP]  = periph_evt.low_supply;
        pflag_set[B_CCP2]     = ccp_hit;
    end

    // Flags latch events independent of every enable
    tlpic_flag_bank #(
        .W    (DAT_W),
        .IMPL (PFLAG2_IMPL),
        .RST  (PFLAG2_RST)
    ) u_pflag2 (
        .clk_sys (clk_sys),
        .srst    (srst),
        .set_evt (pflag_set),
        .wr_en   (wr_pflag2),
        .wr_data (reg_wdata),
        .flags_r (pflag2_r)
    );

    tlpic_flag_bank #(
        .W    (1),
        .IMPL (1'b1),
        .RST  (1'b0)
    ) u_ext_flag (
        .clk_sys (clk_sys),
        .srst    (srst),
        .set_evt (ext_edge),
        .wr_en   (wr_ext),
        .wr_data (reg_wdata[B_EXT_FLG]),
        .flags_r (ext_flag_r)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ext_pin_r <= 1'b0;
        end else begin
            ext_pin_r <= ext_pin;
        end
    end

    // Priority feature enable and per-source configuration registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prio_en_r  <= 1'b0;
            ext_en_r   <= 1'b0;
            ext_prio_r <= EXT_PRIO_RST;
            pen2_r     <= PEN2_RST;
            pprio2_r   <= PPRIO2_RST & PFLAG2_IMPL;
        end else if (reg_wr) begin
            if (reg_addr == OFF_RST_CTRL) begin
                prio_en_r <= reg_wdata[B_PRIO_EN];
            end
            if (reg_addr == OFF_IRQ_CTRL) begin
                ext_en_r <= reg_wdata[B_EXT_EN];
            end
            if (reg_addr == OFF_EXT_CFG) begin
                ext_prio_r <= reg_wdata[B_EXT_PRIO];
            end
            if (reg_addr == OFF_PEN2) begin
                pen2_r <= reg_wdata & PFLAG2_IMPL;
            end
            if (reg_addr == OFF_PPRIO2) begin
                pprio2_r <= reg_wdata & PFLAG2_IMPL;
            end
        end
    end

    // Candidate levels; compatibility ignores priority bits
    always_comb begin
        any_per = |(pflag2_r & pen2_r);
        any_hi  = src_live(pflag2_r, pen2_r, pprio2_r, 1'b1)
                  || (ext_flag_r[0] && ext_en_r && ext_prio_r);
        any_lo  = src_live(pflag2_r, pen2_r, pprio2_r, 1'b0)
                  || (ext_flag_r[0] && ext_en_r && !ext_prio_r);
        if (prio_en_r) begin
            cand_hi_nxt = gie_hi_r && any_hi;
            cand_lo_nxt = gie_lo_r && any_lo;
        end else begin
            cand_hi_nxt = gie_hi_r
                          && ((ext_flag_r[0] && ext_en_r) || (gie_lo_r && any_per));
            cand_lo_nxt = 1'b0;
        end
    end

    // One stage of request registration fixes the pin-to-vector latency
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cand_hi_r <= 1'b0;
            cand_lo_r <= 1'b0;
        end else begin
            cand_hi_r <= cand_hi_nxt;
            cand_lo_r <= cand_lo_nxt;
        end
    end

    // Enables rechecked live so a level is never taken twice
    assign take_hi = instr_done && cand_hi_r && gie_hi_r
                     && (svc_r == SVC_NONE || svc_r == SVC_LO);
    assign take_lo = instr_done && cand_lo_r && gie_lo_r && !take_hi
                     && prio_en_r && (svc_r == SVC_NONE);

    always_comb begin
        svc_nxt = svc_r;
        if (take_hi) begin
            svc_nxt = (svc_r == SVC_LO) ? SVC_HI_OVER_LO : SVC_HI;
        end else if (take_lo) begin
            svc_nxt = SVC_LO;
        end else if (ret_irq) begin
            unique case (svc_r)
                SVC_HI_OVER_LO: svc_nxt = SVC_LO;
                SVC_HI:         svc_nxt = SVC_NONE;
                SVC_LO:         svc_nxt = SVC_NONE;
                SVC_NONE:       svc_nxt = SVC_NONE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            svc_r <= SVC_NONE;
        end else begin
            svc_r <= svc_nxt;
        end
    end

    // Global enables; hardware entry clear overrides a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gie_hi_r <= 1'b0;
            gie_lo_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                gie_hi_r <= reg_wdata[B_GIE_HI];
                gie_lo_r <= reg_wdata[B_GIE_LO];
            end
            if (ret_irq && !take_hi && !take_lo) begin
                if (svc_r == SVC_HI || svc_r == SVC_HI_OVER_LO) begin
                    gie_hi_r <= 1'b1;
                end else if (svc_r == SVC_LO) begin
                    gie_lo_r <= 1'b1;
                end
            end
            if (take_hi) begin
                gie_hi_r <= 1'b0;
            end
            if (take_lo) begin
                gie_lo_r <= 1'b0;
            end
        end
    end

    // Vector pulse: core pushes return address and loads addr
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vec_r <= '0;
        end else begin
            vec_r.valid    <= take_hi || take_lo;
            vec_r.push_ret <= take_hi || take_lo;
            vec_r.high     <= take_hi;
            vec_r.addr     <= take_lo ? LO_VEC_ADDR : HI_VEC_ADDR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hi_active_r <= 1'b0;
            lo_active_r <= 1'b0;
        end else begin
            hi_active_r <= (svc_nxt == SVC_HI) || (svc_nxt == SVC_HI_OVER_LO);
            lo_active_r <= (svc_nxt == SVC_LO) || (svc_nxt == SVC_HI_OVER_LO);
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            OFF_IRQ_CTRL: begin
                rd_mux[B_GIE_HI]  = gie_hi_r;
                rd_mux[B_GIE_LO]  = gie_lo_r;
                rd_mux[B_EXT_EN]  = ext_en_r;
                rd_mux[B_EXT_FLG] = ext_flag_r[0];
            end
            OFF_RST_CTRL: rd_mux[B_PRIO_EN] = prio_en_r;
            OFF_PFLAG2:   rd_mux = pflag2_r & PFLAG2_IMPL;
            OFF_PEN2:     rd_mux = pen2_r;
            OFF_PPRIO2:   rd_mux = pprio2_r;
            OFF_EXT_CFG:  rd_mux[B_EXT_PRIO] = ext_prio_r;
            OFF_SVC_STAT: begin
                rd_mux[B_ST_HI] = hi_active_r;
                rd_mux[B_ST_LO] = lo_active_r;
            end
            default:      rd_mux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata_r <= '0;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    AST_HI_VEC_ADDR: assert property (@(posedge clk_sys) disable iff (srst)
        vec_r.valid |-> (vec_r.addr == (vec_r.high ? HI_VEC_ADDR : LO_VEC_ADDR)))
        else $error("Wrong vector address");

    AST_COMPAT_VEC: assert property (@(posedge clk_sys) disable iff (srst)
        (take_hi || take_lo) && !prio_en_r |=> vec_r.addr == HI_VEC_ADDR)
        else $error("Compatibility mode used low vector");

    AST_GIE_CLEARED: assert property (@(posedge clk_sys) disable iff (srst)
        vec_r.valid |-> (vec_r.high ? !gie_hi_r : !gie_lo_r))
        else $error("Global enable not cleared on entry");

    AST_NO_LO_IN_HI: assert property (@(posedge clk_sys) disable iff (srst)
        hi_active_r && !$past(take_hi) |-> !(vec_r.valid && !vec_r.high))
        else $error("Low serviced during high");

    AST_PREEMPT: assert property (@(posedge clk_sys) disable iff (srst)
        lo_active_r && take_hi |=> vec_r.valid && vec_r.high && hi_active_r && lo_active_r)
        else $error("High did not preempt low");

    AST_RET_RESTORE: assert property (@(posedge clk_sys) disable iff (srst)
        ret_irq && svc_r == SVC_HI && !take_hi && !take_lo && !wr_ctrl
        |=> gie_hi_r && !hi_active_r)
        else $error("Return did not restore enable");

    AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        reg_rd && reg_addr == OFF_PFLAG2 |=> (reg_rdata_r & ~PFLAG2_IMPL) == '0)
        else $error("Unimplemented flag bit read nonzero");

    AST_OSC_STICKY: assert property (@(posedge clk_sys) disable iff (srst)
        periph_evt.osc_fail ##1 !wr_pflag2 |=> pflag2_r[B_OSC_FAIL])
        else $error("Oscillator fail flag not sticky");

    AST_PWM_NO_CCP: assert property (@(posedge clk_sys) disable iff (srst)
        !pflag2_r[B_CCP2] && !wr_pflag2 && ccp_mode == CCP_PWM |=> !pflag2_r[B_CCP2])
        else $error("Capture flag set in PWM mode");

    AST_EXT_LATENCY: assert property (@(posedge clk_sys) disable iff (srst)
        ext_edge && ext_en_r && svc_r == SVC_NONE && !reg_wr
        && (prio_en_r && !ext_prio_r ? gie_lo_r : gie_hi_r)
        && !cand_hi_r && !cand_hi_nxt && !cand_lo_r && !cand_lo_nxt
        ##1 instr_done && !reg_wr ##1 instr_done && !reg_wr
        |=> ##[0:1] vec_r.valid)
        else $error("External interrupt latency exceeded");

    AST_SIMUL_HI_FIRST: assert property (@(posedge clk_sys) disable iff (srst)
        take_hi && cand_lo_r && prio_en_r |=> vec_r.high && !lo_active_r)
        else $error("Low taken ahead of high");

endmodule // tlpic_ctrl

// >>> tlpic_core_model.sv
// Purpose: Behavioural core sequencer facing the interrupt controller
// Assumes: Vector pulses last one cycle and never meet a return
// Notes:   Idle pc is fixed so return addresses are easy to predict
module tlpic_core_model
    import tlpic_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire tlpic_vec_t       vec_r,
    input  wire logic             slow,
    input  wire logic             ret_req,
    output logic                  instr_done,
    output logic                  ret_irq,
    output logic      [VEC_W-1:0] pc_r
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [VEC_W-1:0] stack_r [4];
    logic [1:0]       sp_r;

    // Slow gives two-cycle instructions, the worst spacing the controller allows
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            instr_done <= 1'b0;
            ret_irq    <= 1'b0;
        end else begin
            instr_done <= slow ? ~instr_done : 1'b1;
            ret_irq    <= ret_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pc_r <= 21'h000100;
            sp_r <= 2'h0;
        end else if (vec_r.valid && vec_r.push_ret) begin
            stack_r[sp_r] <= pc_r;
            sp_r          <= sp_r + 2'h1;
            pc_r          <= vec_r.addr;
        end else if (ret_irq) begin
            pc_r <= stack_r[sp_r - 2'h1];
            sp_r <= sp_r - 2'h1;
        end
    end
endmodule // tlpic_core_model

// >>> tb.sv
// Purpose: Self-checking bench for the two-level interrupt controller
// Assumes: Core model answers every vector and return request
// Notes:   Vector pulses are counted by a monitor, scenarios compare counts
module tb
    import tlpic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk_sys    = 1'b0;
    logic             srst       = 1'b1;
    logic [ADR_W-1:0] reg_addr   = '0;
    logic [DAT_W-1:0] reg_wdata  = '0;
    logic             reg_wr     = 1'b0;
    logic             reg_rd     = 1'b0;
    tlpic_evt_t       periph_evt = '0;
    logic [1:0]       ccp_mode   = CCP_CAPTURE;
    logic             ext_pin    = 1'b0;
    logic             slow       = 1'b0;
    logic             ret_req    = 1'b0;
    logic [DAT_W-1:0] reg_rdata_r;
    logic             instr_done;
    logic             ret_irq;
    tlpic_vec_t       vec_r;
    logic             hi_active_r;
    logic             lo_active_r;
    logic [VEC_W-1:0] pc_r;
    logic [VEC_W-1:0] last_addr = '0;
    logic             last_high = 1'b0;
    int               nvec      = 0;
    int               fails     = 0;
    int               checks    = 0;

    always #12.5 clk_sys = ~clk_sys;

    tlpic_ctrl dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .periph_evt(periph_evt), .ccp_mode(ccp_mode),
        .ext_pin(ext_pin), .instr_done(instr_done), .ret_irq(ret_irq),
        .vec_r(vec_r), .hi_active_r(hi_active_r), .lo_active_r(lo_active_r));

    tlpic_core_model core (.clk_sys(clk_sys), .srst(srst), .vec_r(vec_r),
        .slow(slow), .ret_req(ret_req), .instr_done(instr_done),
        .ret_irq(ret_irq), .pc_r(pc_r));

    always @(posedge clk_sys) begin
        if (vec_r.valid === 1'b1) begin
            nvec      <= nvec + 1;
            last_addr <= vec_r.addr;
            last_high <= vec_r.high;
        end
    end

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata_r, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(input tlpic_evt_t e);
        @(posedge clk_sys);
        periph_evt <= e;
        @(posedge clk_sys);
        periph_evt <= '0;
        idle(6);
    endtask

    // Long tail lets a pending vector land before the caller compares
    task automatic ret_pulse();
        @(posedge clk_sys);
        ret_req <= 1'b1;
        @(posedge clk_sys);
        ret_req <= 1'b0;
        idle(8);
    endtask

    task automatic t_reset();
        rd(OFF_IRQ_CTRL, 8'h00);
        rd(OFF_RST_CTRL, 8'h00);
        rd(OFF_PFLAG2, PFLAG2_RST);
        rd(OFF_PPRIO2, PPRIO2_RST);
        rd(OFF_EXT_CFG, 8'h04);
        rd(OFF_PEN2, PEN2_RST);
        rd(OFF_SVC_STAT, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
    endtask

    task automatic t_flags();
        pulse(tlpic_evt_t'(4'hF));
        rd(OFF_PFLAG2, 8'h95);
        wr(OFF_PFLAG2, 8'h00);
        rd(OFF_PFLAG2, 8'h00);
        @(posedge clk_sys);
        ccp_mode <= CCP_PWM;
        pulse(tlpic_evt_t'(4'h1));
        rd(OFF_PFLAG2, 8'h00);
        @(posedge clk_sys);
        ccp_mode <= CCP_COMPARE;
        pulse(tlpic_evt_t'(4'h1));
        rd(OFF_PFLAG2, 8'h01);
        wr(OFF_PFLAG2, 8'hFF);
        rd(OFF_PFLAG2, 8'h95);
        wr(OFF_PFLAG2, 8'h00);
        chk(nvec, 0);
    endtask

    task automatic t_compat();
        wr(OFF_PPRIO2, 8'h00);
        wr(OFF_PEN2, 8'h80);
        wr(OFF_IRQ_CTRL, 8'h80);
        pulse(tlpic_evt_t'(4'h8));
        chk(nvec, 0);
        wr(OFF_IRQ_CTRL, 8'hC0);
        idle(6);
        chk(nvec, 1);
        chk(last_addr, HI_VEC_ADDR);
        chk(pc_r, HI_VEC_ADDR);
        chk(hi_active_r, 1'b1);
        rd(OFF_IRQ_CTRL, 8'h40);
        wr(OFF_PFLAG2, 8'h00);
        ret_pulse();
        rd(OFF_IRQ_CTRL, 8'hC0);
        chk(pc_r, 21'h000100);
        chk(nvec, 1);
        wr(OFF_IRQ_CTRL, 8'h00);
    endtask

    task automatic t_prio();
        wr(OFF_RST_CTRL, 8'h80);
        rd(OFF_RST_CTRL, 8'h80);
        wr(OFF_PPRIO2, 8'h80);
        wr(OFF_IRQ_CTRL, 8'h40);
        pulse(tlpic_evt_t'(4'hC));
        chk(nvec, 1);
        wr(OFF_IRQ_CTRL, 8'h00);
        wr(OFF_PEN2, 8'h90);
        wr(OFF_IRQ_CTRL, 8'hC0);
        idle(6);
        chk(nvec, 2);
        chk(last_high, 1'b1);
        chk(last_addr, HI_VEC_ADDR);
        rd(OFF_SVC_STAT, 8'h80);
        rd(OFF_IRQ_CTRL, 8'h40);
        wr(OFF_PFLAG2, 8'h10);
        chk(nvec, 2);
        ret_pulse();
        chk(nvec, 3);
        chk(last_addr, LO_VEC_ADDR);
        chk(lo_active_r, 1'b1);
        rd(OFF_IRQ_CTRL, 8'h80);
        pulse(tlpic_evt_t'(4'h8));
        chk(nvec, 4);
        chk(last_addr, HI_VEC_ADDR);
        rd(OFF_SVC_STAT, 8'hC0);
        wr(OFF_PFLAG2, 8'h00);
        ret_pulse();
        rd(OFF_SVC_STAT, 8'h40);
        ret_pulse();
        rd(OFF_IRQ_CTRL, 8'hC0);
        chk(pc_r, 21'h000100);
        chk(nvec, 4);
        wr(OFF_IRQ_CTRL, 8'h00);
    endtask

    task automatic t_ext(input logic s);
        int n;
        n = 0;
        @(posedge clk_sys);
        slow <= s;
        wr(OFF_IRQ_CTRL, 8'h90);
        @(posedge clk_sys);
        ext_pin <= 1'b1;
        while (vec_r.valid !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n >= 3 && n <= 4, 1'b1);
        rd(OFF_IRQ_CTRL, 8'h12);
        @(posedge clk_sys);
        ext_pin <= 1'b0;
        wr(OFF_IRQ_CTRL, 8'h10);
        ret_pulse();
        rd(OFF_IRQ_CTRL, 8'h90);
        wr(OFF_IRQ_CTRL, 8'h00);
    endtask

    initial begin
        #100us;
        fails++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_flags();
        t_compat();
        t_prio();
        t_ext(1'b0);
        t_ext(1'b1);
        close_out();
    end
endmodule // tb
